// [rtl/dachost_top.sv]
// host controller that drives a serial/byte 16-bit converter through its pins
// assumes APB software access on CLK_I and a device wired directly to the pins
`timescale 1ns/1ps
`default_nettype none
`include "dachost_consts.svh"

module dachost_top (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic SERIAL_MODE_SELECT_N_O,
    output logic [7:0] BYTE_DATA_BUS_O,
    output logic UPPER_BYTE_STROBE_N_O,
    output logic LOWER_BYTE_STROBE_N_O,
    output logic CHIP_SELECT_N_O,
    output logic OUTPUT_CLEAR_N_O,
    output logic CONVERTER_LATCH_LOAD_O,
    input wire logic SERIAL_CHAIN_OUT_I
);

    localparam logic [7:0] HALF_CYC = 8'(`DACHOST_CS_HALF_CYC);
    localparam logic [7:0] STB_CYC = 8'(`DACHOST_STROBE_CYC);

    logic rst_meta_q;
    logic rst_n;
    dachost_pkg::dachost_regs_t q;
    dachost_pkg::dachost_regs_t d;
    logic setup_ph;
    logic access_wr;
    logic mapped;
    logic busy;

    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flops so every state flop leaves reset together
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // serial bit for position n, in the order software chose
    function automatic logic ser_bit(input logic [15:0] code, input logic msb,
                                     input logic [3:0] n);
        ser_bit = msb ? code[4'hF - n] : code[n];
    endfunction : ser_bit

    ////////////////////////////////////////////////////////////////////////////
    // bus decode; zero-wait slave, frozen along with everything else by CE_I
    assign setup_ph = PSEL_I && !PENABLE_I;
    assign access_wr = PSEL_I && PENABLE_I && PWRITE_I && CE_I;
    assign mapped = (PADDR_I == `DACHOST_ADDR_CTRL) || (PADDR_I == `DACHOST_ADDR_DATA) ||
                    (PADDR_I == `DACHOST_ADDR_CMD) || (PADDR_I == `DACHOST_ADDR_STATUS);
    assign busy = (q.st != dachost_pkg::ST_IDLE) || (q.pend != 3'h0);
    assign PREADY_O = CE_I;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
    assign PRDATA_O = q.prdata;

    // pins straight from flops so the device sees glitch-free strobes
    assign SERIAL_MODE_SELECT_N_O = q.ser_n;
    assign BYTE_DATA_BUS_O = q.dbus;
    assign UPPER_BYTE_STROBE_N_O = q.ubs_n;
    assign LOWER_BYTE_STROBE_N_O = q.lbs_n;
    assign CHIP_SELECT_N_O = q.cs_n;
    assign OUTPUT_CLEAR_N_O = q.clr_n;
    assign CONVERTER_LATCH_LOAD_O = q.converter_latch_load;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic: register file, chain sampler and pin sequencer
    always_comb begin
        d = q;
        if (CE_I) begin
            // chain output comes from another device, so it is synchronised
            d.sy1 = SERIAL_CHAIN_OUT_I;
            d.sy2 = q.sy1;
            // read data captured in the setup phase, stable through access
            if (setup_ph) begin
                unique case (PADDR_I)
                    `DACHOST_ADDR_CTRL: d.prdata = {29'h0, q.clr_bip, q.msb_first, q.byte_mode};
                    `DACHOST_ADDR_DATA: d.prdata = {16'h0, q.code};
                    `DACHOST_ADDR_STATUS: d.prdata = {q.chain, 15'h0, busy};
                    default: d.prdata = 32'h0;
                endcase
            end
            // writes to settings are refused while a sequence runs, so pins never
            // change mode or data under an active strobe
            if (access_wr && !busy) begin
                unique case (PADDR_I)
                    `DACHOST_ADDR_CTRL: begin
                        d.byte_mode = PWDATA_I[`DACHOST_CTRL_BYTE_MODE];
                        d.msb_first = PWDATA_I[`DACHOST_CTRL_MSB_FIRST];
                        d.clr_bip = PWDATA_I[`DACHOST_CTRL_CLR_BIPOLAR];
                    end
                    `DACHOST_ADDR_DATA: d.code = PWDATA_I[15:0];
                    `DACHOST_ADDR_CMD: d.pend = PWDATA_I[2:0];
                    default: ;
                endcase
            end
            unique case (q.st)
                dachost_pkg::ST_IDLE: begin
                    // idle levels: mode pin follows control, upper strobe and chip select inactive
                    d.ser_n = q.byte_mode;
                    d.ubs_n = 1'b1;
                    // in serial mode the lower strobe just holds the clear target
                    d.lbs_n = q.byte_mode ? 1'b1 : q.clr_bip;
                    d.dbus = {6'h00, q.msb_first, 1'b0};
                    d.cs_n = 1'b1;
                    d.clr_n = 1'b1;
                    d.converter_latch_load = 1'b0;
                    // commands run send, then load, then clear
                    if (q.pend[`DACHOST_CMD_SEND]) begin
                        d.pend[`DACHOST_CMD_SEND] = 1'b0;
                        d.bitn = 5'h00;
                        if (q.byte_mode) begin
                            d.st = dachost_pkg::ST_BYTE_SET;
                            d.cnt = HALF_CYC - 8'h01;
                        end else begin
                            d.st = dachost_pkg::ST_SER_LOW;
                            d.cnt = HALF_CYC - 8'h01;
                            d.cs_n = 1'b0;
                            d.dbus[0] = ser_bit(q.code, q.msb_first, 4'h0);
                        end
                    end else if (q.pend[`DACHOST_CMD_LOAD]) begin
                        // a load alone restores the last word after a clear
                        d.pend[`DACHOST_CMD_LOAD] = 1'b0;
                        d.st = dachost_pkg::ST_LOAD;
                        d.cnt = STB_CYC - 8'h01;
                        d.converter_latch_load = 1'b1;
                    end else if (q.pend[`DACHOST_CMD_CLEAR]) begin
                        d.pend[`DACHOST_CMD_CLEAR] = 1'b0;
                        d.st = dachost_pkg::ST_CLR_SET;
                        d.cnt = HALF_CYC - 8'h01;
                        // target chosen before the clear edge; low byte is re-driven
                        // so a transparent low latch keeps its own contents
                        d.lbs_n = q.clr_bip;
                        d.dbus = q.code[7:0];
                    end
                end
                dachost_pkg::ST_SER_LOW: begin
                    d.cnt = q.cnt - 8'h01;
                    if (q.cnt == 8'h00) begin
                        d.cs_n = 1'b1;
                        d.st = dachost_pkg::ST_SER_HIGH;
                        d.cnt = HALF_CYC - 8'h01;
                    end
                end
                dachost_pkg::ST_SER_HIGH: begin
                    d.cnt = q.cnt - 8'h01;
                    if (q.cnt == 8'h00) begin
                        // sampled late in the high half so the chain bit has settled
                        d.chain = {q.chain[14:0], q.sy2};
                        if (q.bitn == 5'h0F) begin
                            d.st = dachost_pkg::ST_IDLE;
                        end else begin
                            d.bitn = q.bitn + 5'h01;
                            d.cs_n = 1'b0;
                            d.dbus[0] = ser_bit(q.code, q.msb_first, 4'(q.bitn + 5'h01));
                            d.st = dachost_pkg::ST_SER_LOW;
                            d.cnt = HALF_CYC - 8'h01;
                        end
                    end
                end
                dachost_pkg::ST_BYTE_SET: begin
                    // byte changes one cycle after the previous strobe released
                    d.dbus = q.bitn[0] ? q.code[7:0] : q.code[15:8];
                    d.cnt = q.cnt - 8'h01;
                    if (q.cnt == 8'h00) begin
                        d.st = dachost_pkg::ST_BYTE_STB;
                        d.cnt = STB_CYC - 8'h01;
                        d.cs_n = 1'b0;
                        d.ubs_n = q.bitn[0];
                        d.lbs_n = ~q.bitn[0];
                    end
                end
                dachost_pkg::ST_BYTE_STB: begin
                    d.cnt = q.cnt - 8'h01;
                    if (q.cnt == 8'h00) begin
                        // each half is a separate strobe, high half first
                        d.ubs_n = 1'b1;
                        d.lbs_n = 1'b1;
                        d.cs_n = 1'b1;
                        d.bitn = 5'h01;
                        d.cnt = HALF_CYC - 8'h01;
                        d.st = q.bitn[0] ? dachost_pkg::ST_IDLE : dachost_pkg::ST_BYTE_SET;
                    end
                end
                dachost_pkg::ST_LOAD: begin
                    d.cnt = q.cnt - 8'h01;
                    if (q.cnt == 8'h00) begin
                        d.converter_latch_load = 1'b0;
                        d.st = dachost_pkg::ST_IDLE;
                    end
                end
                dachost_pkg::ST_CLR_SET: begin
                    d.cnt = q.cnt - 8'h01;
                    if (q.cnt == 8'h00) begin
                        d.clr_n = 1'b0;
                        d.st = dachost_pkg::ST_CLR_PULSE;
                        d.cnt = STB_CYC - 8'h01;
                    end
                end
                dachost_pkg::ST_CLR_PULSE: begin
                    d.cnt = q.cnt - 8'h01;
                    if (q.cnt == 8'h00) begin
                        d.clr_n = 1'b1;
                        d.st = dachost_pkg::ST_CLR_HOLD;
                        d.cnt = HALF_CYC - 8'h01;
                    end
                end
                dachost_pkg::ST_CLR_HOLD: begin
                    // target held past the clear edge, then idle levels return
                    d.cnt = q.cnt - 8'h01;
                    if (q.cnt == 8'h00) begin
                        d.st = dachost_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; converter content is unknown until software loads or clears
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= dachost_pkg::ST_IDLE;
            q.ser_n <= 1'b1;
            q.dbus <= 8'h00;
            q.ubs_n <= 1'b1;
            q.lbs_n <= 1'b1;
            q.cs_n <= 1'b1;
            q.clr_n <= 1'b1;
            {q.clr_bip, q.msb_first, q.byte_mode} <= `DACHOST_CTRL_RESET;
            q.code <= `DACHOST_CODE_RESET;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks: rising chip-select edges counted per serial send
    logic [4:0] edges_q;
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            edges_q <= 5'h00;
        end else if (CE_I) begin
            if (q.st == dachost_pkg::ST_IDLE) begin
                edges_q <= 5'h00;
            end else if (!q.cs_n && d.cs_n) begin
                edges_q <= edges_q + 5'h01;
            end
        end
    end

    a_mode_pin_idle: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I)
        q.st == dachost_pkg::ST_IDLE |=> q.ser_n == $past(q.byte_mode))
        else $error("mode pin does not follow control");
    a_shift_order_pin: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I)
        !q.ser_n && !q.cs_n |-> q.dbus[1] == q.msb_first)
        else $error("shift order pin wrong during serial strobe");
    a_upper_quiet_serial: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I)
        !q.ser_n |-> q.ubs_n)
        else $error("upper strobe active in serial mode");
    a_serial_data_stable: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I)
        !q.ser_n && $rose(q.cs_n) |-> $stable(q.dbus[0]) && $past(q.cs_n, 2) == 1'b0)
        else $error("serial data moved at chip-select rise");
    a_sixteen_edges: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I)
        q.st == dachost_pkg::ST_SER_HIGH && d.st == dachost_pkg::ST_IDLE
        |-> edges_q == 5'h10)
        else $error("serial send did not give sixteen edges");
    a_load_width: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I)
        $rose(q.converter_latch_load) |-> q.converter_latch_load[*4] ##1 !q.converter_latch_load)
        else $error("load pulse width wrong");
    a_clear_target: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I)
        $fell(q.clr_n) |-> q.lbs_n == q.clr_bip && $past(q.lbs_n, 3) == q.clr_bip
        ##1 (!q.clr_n && q.lbs_n == q.clr_bip)[*3] ##1 q.clr_n)
        else $error("clear target not held around clear");
    a_byte_high_half: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I)
        !q.ubs_n |-> q.dbus == q.code[15:8] && q.lbs_n && q.ser_n)
        else $error("upper strobe with wrong byte");
    a_byte_low_half: assert property (@(posedge CLK_I) disable iff (!rst_n || !CE_I)
        $fell(q.lbs_n) && q.byte_mode && q.clr_n && q.st == dachost_pkg::ST_BYTE_STB
        |-> q.dbus == q.code[7:0] && q.ubs_n)
        else $error("lower strobe with wrong byte");

    c_serial_send: cover property (@(posedge CLK_I) disable iff (!rst_n)
        q.st == dachost_pkg::ST_SER_HIGH && d.st == dachost_pkg::ST_IDLE);
    c_byte_send: cover property (@(posedge CLK_I) disable iff (!rst_n)
        q.st == dachost_pkg::ST_BYTE_STB && q.bitn[0] && d.st == dachost_pkg::ST_IDLE);
    c_load: cover property (@(posedge CLK_I) disable iff (!rst_n) $fell(q.converter_latch_load));
    c_clear_bipolar: cover property (@(posedge CLK_I) disable iff (!rst_n)
        $fell(q.clr_n) && q.lbs_n);

endmodule : dachost_top

`default_nettype wire

// [rtl/dachost_consts.svh]
// constants for the serial/byte converter host controller
// assumes a 100 MHz system clock and APB register access with 32-bit data
// Functional notes
// - after clear, reload by load pulse alone
// - chained devices need separate load unless simultaneous
// - halves load in any order, independently
// - byte mode: set lower strobe before clearing
`ifndef DACHOST_CONSTS_SVH
`define DACHOST_CONSTS_SVH

// register byte offsets
`define DACHOST_ADDR_CTRL 12'h000
`define DACHOST_ADDR_DATA 12'h004
`define DACHOST_ADDR_CMD 12'h008
`define DACHOST_ADDR_STATUS 12'h00C

// control register fields
`define DACHOST_CTRL_BYTE_MODE 0
`define DACHOST_CTRL_MSB_FIRST 1
`define DACHOST_CTRL_CLR_BIPOLAR 2

// command register fields
`define DACHOST_CMD_SEND 0
`define DACHOST_CMD_LOAD 1
`define DACHOST_CMD_CLEAR 2

// status register fields
`define DACHOST_STAT_BUSY 0
`define DACHOST_STAT_CHAIN_LSB 16

// reset values
`define DACHOST_CTRL_RESET 3'h0
`define DACHOST_CODE_RESET 16'h0000

// timing
`define DACHOST_CLK_PERIOD_NS 10
`define DACHOST_CS_HALF_NS 40
`define DACHOST_STROBE_NS 40
`define DACHOST_CS_HALF_CYC \
    ((`DACHOST_CS_HALF_NS + `DACHOST_CLK_PERIOD_NS - 1) / `DACHOST_CLK_PERIOD_NS)
`define DACHOST_STROBE_CYC \
    ((`DACHOST_STROBE_NS + `DACHOST_CLK_PERIOD_NS - 1) / `DACHOST_CLK_PERIOD_NS)

`endif

// [rtl/dachost_pkg.sv]
// types of the converter host controller
// assumes nothing beyond a SystemVerilog elaborator
package dachost_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SER_LOW,
        ST_SER_HIGH,
        ST_BYTE_SET,
        ST_BYTE_STB,
        ST_LOAD,
        ST_CLR_SET,
        ST_CLR_PULSE,
        ST_CLR_HOLD
    } dachost_state_t;

    typedef struct packed {
        dachost_state_t st;
        logic [7:0] cnt;
        logic [4:0] bitn;
        logic [2:0] pend;
        logic byte_mode;
        logic msb_first;
        logic clr_bip;
        logic [15:0] code;
        logic [15:0] chain;
        logic sy1;
        logic sy2;
        logic [31:0] prdata;
        logic ser_n;
        logic [7:0] dbus;
        logic ubs_n;
        logic lbs_n;
        logic cs_n;
        logic clr_n;
        logic converter_latch_load;
    } dachost_regs_t;

endpackage : dachost_pkg

// [tb/dachost_dev_model.sv]
// behavioural model of the converter's digital input latches
// assumes its pins are wired straight to the host controller; it has no clock
`timescale 1ns/1ps
`default_nettype none

module dachost_dev_model (
    input wire logic ser_n_i,
    input wire logic [7:0] dbus_i,
    input wire logic ubs_n_i,
    input wire logic lbs_n_i,
    input wire logic cs_n_i,
    input wire logic clr_n_i,
    input wire logic converter_latch_load_i,
    output logic serial_chain_out_o,
    output logic [15:0] rank1_o,
    output logic [15:0] latch_o
);
    logic cs_last = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // one process owns the first rank so it has a single driver; serial shift on a
    // clean chip-select rise only, both ranks start unknown on purpose
    always @(cs_n_i or ser_n_i or dbus_i or ubs_n_i or lbs_n_i) begin
        if (cs_n_i === 1'b1 && cs_last === 1'b0 && !ser_n_i) begin
            if (dbus_i[1]) begin
                serial_chain_out_o = rank1_o[15];
                rank1_o = {rank1_o[14:0], dbus_i[0]};
            end else begin
                serial_chain_out_o = rank1_o[0];
                rank1_o = {dbus_i[0], rank1_o[15:1]};
            end
        end
        cs_last = cs_n_i;
        // byte halves are transparent while their strobe is low; both ignored in serial
        if (ser_n_i && !ubs_n_i) begin
            rank1_o[15:8] = dbus_i;
        end
        if (ser_n_i && !lbs_n_i) begin
            rank1_o[7:0] = dbus_i;
        end
    end

    // clear wins over load; the first rank is never touched by it
    always @* begin
        if (!clr_n_i) begin
            latch_o = lbs_n_i ? 16'h8000 : 16'h0000;
        end else if (converter_latch_load_i) begin
            latch_o = rank1_o;
        end
    end
endmodule : dachost_dev_model

`default_nettype wire

// [tb/dachost_top_tb.sv]
// self-checking bench for the converter host controller
// assumes the device model on the pins and an APB master made of tasks
`timescale 1ns/1ps
`default_nettype none
`include "dachost_consts.svh"

module dachost_top_tb;
    logic clk, rst_n, ce, psel, penable, pwrite, pslverr, pready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic ser_n, ubs_n, lbs_n, cs_n, clr_n, converter_latch_load, serial_chain_out, e;
    logic [7:0] dbus;
    logic [15:0] rank1, latch;
    int fail_count = 0;
    int n_compared = 0;

    ////////////////////////////////////////////////////////////////////////////////
    dachost_top dut (.CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .SERIAL_MODE_SELECT_N_O(ser_n), .BYTE_DATA_BUS_O(dbus),
        .UPPER_BYTE_STROBE_N_O(ubs_n), .LOWER_BYTE_STROBE_N_O(lbs_n),
        .CHIP_SELECT_N_O(cs_n), .OUTPUT_CLEAR_N_O(clr_n),
        .CONVERTER_LATCH_LOAD_O(converter_latch_load), .SERIAL_CHAIN_OUT_I(serial_chain_out));

    // one device only, so its load pin is private to it
    dachost_dev_model u_dev (.ser_n_i(ser_n), .dbus_i(dbus), .ubs_n_i(ubs_n),
        .lbs_n_i(lbs_n), .cs_n_i(cs_n), .clr_n_i(clr_n), .converter_latch_load_i(converter_latch_load),
        .serial_chain_out_o(serial_chain_out), .rank1_o(rank1), .latch_o(latch));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            n_compared++;
            if (seen !== exp) begin
                fail_count++;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask : check

    // one APB transfer; the leading edge keeps back-to-back calls apart
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        begin
            n = 0;
            @(posedge clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= wr;
            paddr <= a;
            pwdata <= wd;
            @(posedge clk);
            penable <= 1'b1;
            do begin
                @(posedge clk);
                n++;
            end while (pready !== 1'b1 && n < 100);
            if (n >= 100) fail_count++;
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    // poll busy with a bounded count, then leave the last status in r
    task automatic wait_idle();
        int n;
        begin
            n = 0;
            do begin
                apb(1'b0, `DACHOST_ADDR_STATUS, 32'h0, r, e);
                n++;
            end while (r[0] !== 1'b0 && n < 300);
            if (n >= 300) fail_count++;
        end
    endtask : wait_idle

    task automatic send(input logic [31:0] ctl, input logic [31:0] code,
                        input logic [31:0] cmd);
        begin
            apb(1'b1, `DACHOST_ADDR_CTRL, ctl, r, e);
            apb(1'b1, `DACHOST_ADDR_DATA, code, r, e);
            apb(1'b1, `DACHOST_ADDR_CMD, cmd, r, e);
            wait_idle();
        end
    endtask : send

    task automatic tally_and_finish();
        begin
            $display("compared %0d, mismatches %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask : tally_and_finish

    // watchdog: the sequence needs well under a tenth of this
    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, `DACHOST_ADDR_CTRL, 32'h0, r, e);
        check(r, 32'h0);
        apb(1'b0, `DACHOST_ADDR_DATA, 32'h0, r, e);
        check(r, 32'h0);
        apb(1'b0, 12'h010, 32'h0, r, e);
        check(r, 32'h0);
        check({31'h0, e}, 32'h1);
        // serial msb first with load, then a send without load
        send(32'h2, 32'hA5C3, 32'h3);
        check({31'h0, ser_n}, 32'h0);
        check({16'h0, latch}, 32'hA5C3);
        send(32'h2, 32'h3C5A, 32'h1);
        check({16'h0, latch}, 32'hA5C3);
        check({16'h0, r[31:16]}, 32'hA5C3);
        send(32'h2, 32'h3C5A, 32'h2);
        check({16'h0, latch}, 32'h3C5A);
        // lsb first: the old word leaves low bit first
        send(32'h0, 32'h1E87, 32'h3);
        check({16'h0, latch}, 32'h1E87);
        check({16'h0, r[31:16]}, 32'h5A3C);
        // a data write during a send is dropped
        apb(1'b1, `DACHOST_ADDR_CMD, 32'h1, r, e);
        apb(1'b1, `DACHOST_ADDR_DATA, 32'hFFFF, r, e);
        wait_idle();
        apb(1'b0, `DACHOST_ADDR_DATA, 32'h0, r, e);
        check(r, 32'h1E87);
        // unipolar clear keeps the first rank, a bare load restores
        send(32'h0, 32'h1E87, 32'h4);
        check({16'h0, latch}, 32'h0000);
        check({16'h0, rank1}, 32'h1E87);
        send(32'h0, 32'h1E87, 32'h2);
        check({16'h0, latch}, 32'h1E87);
        // byte mode write, then bipolar clear and restore
        send(32'h1, 32'hC381, 32'h3);
        check({31'h0, ser_n}, 32'h1);
        check({16'h0, latch}, 32'hC381);
        send(32'h5, 32'hC381, 32'h4);
        check({16'h0, latch}, 32'h8000);
        check({16'h0, rank1}, 32'hC381);
        send(32'h5, 32'hC381, 32'h2);
        check({16'h0, latch}, 32'hC381);
        // serial mode clear to bipolar zero through the lower strobe level
        send(32'h6, 32'hC381, 32'h4);
        check({16'h0, latch}, 32'h8000);
        // clock enable low holds the bus off
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        #1;
        check({31'h0, pready}, 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        tally_and_finish();
    end
endmodule : dachost_top_tb

`default_nettype wire
